// file: design/aux_cmp_consts.svh
/*
 * Offsets, field positions, reset values and codes of the auxiliary
 * measurement threshold comparator. Assumes inclusion by bare name.
 */
`ifndef AUX_CMP_CONSTS_SVH
`define AUX_CMP_CONSTS_SVH
// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define IDX_BATT 8'h9e
`define IDX_TEMP 8'h9f
`define IDX_ENA 8'ha3
`define IDX_CFG1 8'ha4
`define IDX_CFG2 8'ha5
`define IDX_STAT 8'hb0
`define IDX_MASK 8'hb1
// ----------------------------------------------------------------
// fields, sources and codes
// ----------------------------------------------------------------
`define ADDR_W 12
`define RES_W 12
`define SRC_HI 15
`define SRC_LO 13
`define DIR_BIT 12
`define THR_HI 11
`define NUM_SRC 8
`define NUM_ENA 4
`define SRC_BATT 3'h6
`define SRC_TEMP 3'h7
`define SRC_RST 3'h0
`define CFG_RST 16'h0000
`define RES_RST 12'h000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: design/aux_cmp_pkg.sv
/*
 * Types of the threshold comparator block: state records of each module.
 * Assumes aux_cmp_consts.svh is on the include path.
 */
`include "aux_cmp_consts.svh"
package aux_cmp_pkg;
	typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_RESP = 1'b1} rd_state_t;
	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [`ADDR_W-1:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		rd_state_t rd;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_state_t;
	typedef struct packed {
		logic event_hit;
	} cmp_state_t;
	typedef struct packed {
		logic [`RES_W-1:0] batt;
		logic [`RES_W-1:0] temp;
		logic [`NUM_ENA-1:0] ena;
		logic [15:0] cfg1;
		logic [15:0] cfg2;
		logic [1:0] stat;
		logic [1:0] mask;
	} top_state_t;
endpackage

// file: design/threshold_comparator.sv
/*
 * One threshold comparator: selects a measured source, compares it with
 * a threshold on each new result and pulses an event one cycle later.
 * Assumes results and their valid strobes come from the core clock domain.
 */
`timescale 1ns/10ps
`include "aux_cmp_consts.svh"
module threshold_comparator
	import aux_cmp_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// configuration
	input wire logic enable_i,
	input wire logic [2:0] source_i,
	input wire logic direction_i,
	input wire logic [`RES_W-1:0] threshold_i,
	// measured results
	input wire logic [`NUM_SRC-1:0][`RES_W-1:0] meas_data_i,
	input wire logic [`NUM_SRC-1:0] meas_valid_i,
	// event
	output logic event_o
);
	cmp_state_t q, d;
	logic [`RES_W-1:0] value;
	logic fresh;

	// pick the selected source; only a fresh result is judged
	always_comb begin
		value = meas_data_i[source_i];
		fresh = meas_valid_i[source_i] & enable_i;
		d.event_hit = 1'b0;
		if (fresh) begin
			// equality never fires, so a value sitting on the threshold stays quiet
			if (direction_i) d.event_hit = value > threshold_i;
			else d.event_hit = value < threshold_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) q <= '0;
		else q <= d;
	end

	assign event_o = q.event_hit;

	AST_BELOW: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		enable_i && meas_valid_i[source_i] && !direction_i && meas_data_i[source_i] < threshold_i |=> event_o)
		else $error("below-threshold result gave no event");
	AST_ABOVE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		enable_i && meas_valid_i[source_i] && direction_i && meas_data_i[source_i] > threshold_i |=> event_o)
		else $error("above-threshold result gave no event");
	AST_EQUAL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		meas_data_i[source_i] == threshold_i |=> !event_o)
		else $error("equal value raised an event");
	AST_DISABLED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!enable_i |=> !event_o)
		else $error("disabled comparator raised an event");
endmodule

// file: design/axil_regport.sv
/*
 * AXI4-Lite slave front end. Turns bus transfers into one-cycle register
 * write and read strobes. Assumes one write and one read in flight at most.
 */
`timescale 1ns/10ps
`include "aux_cmp_consts.svh"
module axil_regport
	import aux_cmp_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// write channels
	input wire logic [`ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read channels
	input wire logic [`ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// register side
	output logic wr_en_o,
	output logic [`ADDR_W-1:0] wr_addr_o,
	output logic [31:0] wr_data_o,
	output logic [3:0] wr_strb_o,
	input wire logic wr_err_i,
	output logic rd_en_o,
	output logic [`ADDR_W-1:0] rd_addr_o,
	input wire logic [31:0] rd_data_i,
	input wire logic rd_err_i
);
	axil_state_t q, d;

	// address and data are caught in either order; the write fires once both are held
	always_comb begin
		d = q;
		wr_en_o = q.aw_got & q.w_got & ~q.bvalid;
		rd_en_o = s_axi_arvalid & (q.rd == RD_IDLE);
		if (s_axi_awvalid && !q.aw_got) begin
			d.aw_got = 1'b1;
			d.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.w_got) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (wr_en_o) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = wr_err_i ? `RESP_SLVERR : `RESP_OKAY;
		end
		if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
		// read data is captured at the address handshake
		case (q.rd)
			RD_IDLE: begin
				if (rd_en_o) begin
					d.rd = RD_RESP;
					d.rdata = rd_data_i;
					d.rresp = rd_err_i ? `RESP_SLVERR : `RESP_OKAY;
				end
			end
			RD_RESP: begin
				if (s_axi_rready) d.rd = RD_IDLE;
			end
			default: d.rd = RD_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) q <= '0;
		else q <= d;
	end

	assign s_axi_awready = ~q.aw_got;
	assign s_axi_wready = ~q.w_got;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = (q.rd == RD_IDLE);
	assign s_axi_rvalid = (q.rd == RD_RESP);
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign wr_addr_o = q.waddr;
	assign wr_data_o = q.wdata;
	assign wr_strb_o = q.wstrb;
	assign rd_addr_o = s_axi_araddr;
endmodule

// file: design/aux_measure_threshold_compare.sv
/*
 * Auxiliary measurement threshold comparators with battery and die
 * temperature readback, behind an AXI4-Lite register slave.
 * Assumes measured results arrive from converter logic on core_clk_i,
 * each with a one-cycle valid strobe, and that the power state machine
 * reset is a synchronous level on the same clock.
 */
`timescale 1ns/10ps
`include "aux_cmp_consts.svh"

// Summary of operation
// - battery result readable, bits 11:0, resets zero
// - die temperature result readable, bits 11:0
// - four enable bits, comparator n at bit n-1
// - enables default off, cleared by state-machine reset
// - source field 15:13 picks one of eight
// - direction zero: event when source below threshold
// - direction one: event when source above threshold
// - unsigned 12-bit threshold, bits 11:0, default zero
// - comparator two has identical independent configuration
// - sources are the measured 12-bit results
module aux_measure_threshold_compare
	import aux_cmp_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic sm_reset_i,
	// measured results, index = source code
	input wire logic [`NUM_SRC-1:0][`RES_W-1:0] meas_data_i,
	input wire logic [`NUM_SRC-1:0] meas_valid_i,
	// register bus write
	input wire logic [`ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// register bus read
	input wire logic [`ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt
	output logic irq_o
);
	// ----------------------------------------------------------------
	// state and wiring
	// ----------------------------------------------------------------
	top_state_t q, d;
	logic wr_en, rd_en, wr_err, rd_err;
	logic [`ADDR_W-1:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	logic [7:0] wr_idx, rd_idx;
	logic wr_ok, rd_ok;
	logic [1:0] cmp_event;
	logic [1:0][15:0] cfg;
	logic [15:0] wmask;

	axil_regport u_bus (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en_o(wr_en),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.wr_strb_o(wr_strb),
		.wr_err_i(wr_err),
		.rd_en_o(rd_en),
		.rd_addr_o(rd_addr),
		.rd_data_i(rd_data),
		.rd_err_i(rd_err)
	);

	// ----------------------------------------------------------------
	// comparators
	// ----------------------------------------------------------------
	assign cfg[0] = q.cfg1;
	assign cfg[1] = q.cfg2;

	// both comparators share one structure, each with its own register
	for (genvar g = 0; g < 2; g++) begin : gen_cmp
		threshold_comparator u_cmp (
			.core_clk_i(core_clk_i),
			.rst_n_i(rst_n_i),
			.enable_i(q.ena[g]),
			.source_i(cfg[g][`SRC_HI:`SRC_LO]),
			.direction_i(cfg[g][`DIR_BIT]),
			.threshold_i(cfg[g][`THR_HI:0]),
			.meas_data_i(meas_data_i),
			.meas_valid_i(meas_valid_i),
			.event_o(cmp_event[g])
		);
	end

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// word index sits above the two byte bits; misaligned addresses are unmapped
	assign wr_idx = wr_addr[9:2];
	assign rd_idx = rd_addr[9:2];
	assign wr_ok = (wr_addr[1:0] == 2'h0) && (wr_addr[`ADDR_W-1:10] == '0);
	assign rd_ok = (rd_addr[1:0] == 2'h0) && (rd_addr[`ADDR_W-1:10] == '0);
	assign wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

	// read-only results answer writes with an error rather than silently dropping them
	always_comb begin
		wr_err = 1'b1;
		if (wr_ok) begin
			case (wr_idx)
				`IDX_ENA, `IDX_CFG1, `IDX_CFG2, `IDX_MASK: wr_err = 1'b0;
				default: wr_err = 1'b1;
			endcase
		end
	end

	// read mux; unused upper bits read zero
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_err = 1'b0;
		case (rd_idx)
			`IDX_BATT: rd_data[`THR_HI:0] = q.batt;
			`IDX_TEMP: rd_data[`THR_HI:0] = q.temp;
			`IDX_ENA: rd_data[`NUM_ENA-1:0] = q.ena;
			`IDX_CFG1: rd_data[15:0] = q.cfg1;
			`IDX_CFG2: rd_data[15:0] = q.cfg2;
			`IDX_STAT: rd_data[1:0] = q.stat;
			`IDX_MASK: rd_data[1:0] = q.mask;
			default: rd_err = 1'b1;
		endcase
		if (!rd_ok) begin
			rd_data = 32'h0000_0000;
			rd_err = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		// readback results follow the latest converter result
		if (meas_valid_i[`SRC_BATT]) d.batt = meas_data_i[`SRC_BATT];
		if (meas_valid_i[`SRC_TEMP]) d.temp = meas_data_i[`SRC_TEMP];
		if (wr_en && !wr_err) begin
			case (wr_idx)
				`IDX_ENA: begin
					if (wr_strb[0]) d.ena = wr_data[`NUM_ENA-1:0];
				end
				`IDX_CFG1: d.cfg1 = (q.cfg1 & ~wmask) | (wr_data[15:0] & wmask);
				`IDX_CFG2: d.cfg2 = (q.cfg2 & ~wmask) | (wr_data[15:0] & wmask);
				`IDX_MASK: begin
					if (wr_strb[0]) d.mask = wr_data[1:0];
				end
				default: d.ena = q.ena;
			endcase
		end
		// reading the status clears it; rdata already holds the old value
		if (rd_en && rd_ok && rd_idx == `IDX_STAT) d.stat = 2'h0;
		// a new event in the clearing cycle survives: set wins
		d.stat = d.stat | cmp_event;
		// the power state machine reset returns enables and sources to default
		if (sm_reset_i) begin
			d.ena = '0;
			d.cfg1[`SRC_HI:`SRC_LO] = `SRC_RST;
			d.cfg2[`SRC_HI:`SRC_LO] = `SRC_RST;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			q.batt <= `RES_RST;
			q.temp <= `RES_RST;
			q.ena <= '0;
			q.cfg1 <= `CFG_RST;
			q.cfg2 <= `CFG_RST;
			q.stat <= 2'h0;
			q.mask <= 2'h0;
		end else begin
			q <= d;
		end
	end

	// level interrupt while any unmasked event is pending
	assign irq_o = |(q.stat & q.mask);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_BATT_LATCH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		meas_valid_i[`SRC_BATT] |=> q.batt == $past(meas_data_i[`SRC_BATT]))
		else $error("battery result not updated");
	AST_TEMP_LATCH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		meas_valid_i[`SRC_TEMP] |=> q.temp == $past(meas_data_i[`SRC_TEMP]))
		else $error("temperature result not updated");
	AST_ENA_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_en && wr_ok && wr_idx == `IDX_ENA && wr_strb[0] && !sm_reset_i
		|=> q.ena == $past(wr_data[`NUM_ENA-1:0]))
		else $error("enable write not stored");
	AST_ENA_SMRESET: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		sm_reset_i |=> q.ena == '0)
		else $error("enables survive state machine reset");
	AST_SRC_SMRESET: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		sm_reset_i |=> q.cfg1[`SRC_HI:`SRC_LO] == `SRC_RST && q.cfg2[`SRC_HI:`SRC_LO] == `SRC_RST)
		else $error("source select survives state machine reset");
	AST_CFG2_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_en && wr_ok && wr_idx == `IDX_CFG2 && wr_strb[1:0] == 2'h3 && !sm_reset_i
		|=> q.cfg2 == $past(wr_data[15:0]) && q.cfg1 == $past(q.cfg1))
		else $error("comparator two config not independent");
	AST_EVENT_STICKY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cmp_event[0] |=> q.stat[0] [*2] or (q.stat[0] ##1 $past(rd_en)))
		else $error("event flag not held");
	// a mask write in the event cycle may legally hide the new event
	AST_IRQ_LEVEL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cmp_event[1] && q.mask[1] && !(wr_en && wr_idx == `IDX_MASK) |=> irq_o)
		else $error("unmasked event gave no interrupt");
	// a status read with no new event leaves nothing pending
	AST_STAT_CLEAR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		rd_en && rd_ok && rd_idx == `IDX_STAT && cmp_event == 2'h0 |=> q.stat == 2'h0)
		else $error("status not cleared by read");
	AST_CFG1_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_en && wr_ok && wr_idx == `IDX_CFG1 && wr_strb[1:0] == 2'h3 && !sm_reset_i
		|=> q.cfg1 == $past(wr_data[15:0]))
		else $error("comparator one config not stored");
	// in the config registers the state machine reset only touches the source field
	AST_THR_KEEP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		sm_reset_i && !wr_en |=> q.cfg1[`DIR_BIT:0] == $past(q.cfg1[`DIR_BIT:0]))
		else $error("threshold lost on state machine reset");
endmodule

// file: bench/meas_source_model.sv
/*
 * Converter-side partner: holds one 12-bit result per source and posts a
 * one-cycle valid strobe for each new result asked of it by the bench.
 * Assumes requests arrive on core_clk_i, one at most per cycle.
 */
`timescale 1ns/10ps
`include "aux_cmp_consts.svh"
module meas_source_model
	import aux_cmp_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// post request from the bench
	input wire logic post_i,
	input wire logic [2:0] post_src_i,
	input wire logic [`RES_W-1:0] post_val_i,
	// results towards the block
	output logic [`NUM_SRC-1:0][`RES_W-1:0] meas_data_o,
	output logic [`NUM_SRC-1:0] meas_valid_o
);
	// results stay put between conversions, like a readback register does
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			meas_data_o <= '0;
			meas_valid_o <= '0;
		end else begin
			meas_valid_o <= '0;
			if (post_i) begin
				meas_data_o[post_src_i] <= post_val_i;
				meas_valid_o[post_src_i] <= 1'b1;
			end
		end
	end
endmodule

// file: bench/test_aux_measure_threshold_compare.sv
/*
 * Self-checking bench: an AXI4-Lite master, a reference model of the
 * registers and comparators, and random traffic from an xorshift source.
 * Assumes the design answers every bus request well inside the timeout.
 */
`timescale 1ns/10ps
`include "aux_cmp_consts.svh"
module test_aux_measure_threshold_compare
	import aux_cmp_pkg::*;
;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sm_reset_i = 1'b0;
	logic post_i = 1'b0;
	logic [2:0] post_src = 3'h0;
	logic [11:0] post_val = 12'h000;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [11:0] s_axi_araddr = 12'h000;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [`NUM_SRC-1:0][`RES_W-1:0] meas_data;
	logic [`NUM_SRC-1:0] meas_valid;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc_cnt = 0;
	// reference model state
	logic [3:0] m_ena = 4'h0;
	logic [1:0] m_mask = 2'h0;
	logic [15:0] m_cfg [2] = '{default: 16'h0};
	logic [11:0] m_res [8] = '{default: 12'h0};
	logic [31:0] rnd = 32'h60aeaf37;
	logic [7:0] idx_tab [7] = '{`IDX_BATT, `IDX_TEMP, `IDX_ENA, `IDX_CFG1, `IDX_CFG2, `IDX_STAT, `IDX_MASK};

	always #25 core_clk_i = ~core_clk_i;

	aux_measure_threshold_compare aux_measure_threshold_compare_inst (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sm_reset_i(sm_reset_i),
		.meas_data_i(meas_data), .meas_valid_i(meas_valid),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_o(irq_o)
	);

	meas_source_model meas_source_model_inst (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .post_i(post_i), .post_src_i(post_src),
		.post_val_i(post_val), .meas_data_o(meas_data), .meas_valid_o(meas_valid)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	function automatic logic [11:0] addr(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic report_and_stop();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// the leading edge keeps two tasks from driving one signal in one step
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge core_clk_i);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge core_clk_i);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				done = 1'b1;
				s_axi_bready <= 1'b0;
				check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
			end
		end
	endtask

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
		logic done;
		done = 1'b0;
		@(posedge core_clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge core_clk_i);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				done = 1'b1;
				d = s_axi_rdata;
				rs = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] rd;
		logic [1:0] rs;
		logic [2:0] s;
		logic [11:0] v;
		logic [1:0] exp;
		int k;
		repeat (12) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		// every register starts at zero
		for (int i = 0; i < 7; i++) begin
			axi_read(addr(idx_tab[i]), rd, rs);
			check("reset value", 32'h0, rd);
		end
		axi_write(addr(`IDX_BATT), 32'h0fff, `RESP_SLVERR);
		axi_read(12'hffc, rd, rs);
		check("unmapped resp", {30'h0, `RESP_SLVERR}, {30'h0, rs});
		// random configurations, one result each, boundary values included
		for (int i = 0; i < 40; i++) begin
			rnd = xs(rnd);
			m_ena = rnd[3:0];
			m_mask = rnd[5:4];
			axi_write(addr(`IDX_ENA), {28'h0, m_ena}, `RESP_OKAY);
			axi_write(addr(`IDX_MASK), {30'h0, m_mask}, `RESP_OKAY);
			for (int c = 0; c < 2; c++) begin
				rnd = xs(rnd);
				m_cfg[c] = rnd[15:0];
				axi_write(addr(c ? `IDX_CFG2 : `IDX_CFG1), {16'h0, m_cfg[c]}, `RESP_OKAY);
			end
			rnd = xs(rnd);
			k = int'(rnd[0]);
			s = m_cfg[k][15:13];
			v = m_cfg[k][11:0] + {10'h0, rnd[2:1]} - 12'h001;
			m_res[s] = v;
			post_src <= s;
			post_val <= v;
			post_i <= 1'b1;
			@(posedge core_clk_i);
			post_i <= 1'b0;
			exp = 2'b00;
			for (int c = 0; c < 2; c++) begin
				if (m_ena[c] && m_cfg[c][15:13] == s && (m_cfg[c][12] ? v > m_cfg[c][11:0] : v < m_cfg[c][11:0]))
					exp[c] = 1'b1;
			end
			repeat (4) @(posedge core_clk_i);
			check("irq", {31'h0, |(exp & m_mask)}, {31'h0, irq_o});
			axi_read(addr(`IDX_STAT), rd, rs);
			check("status", {30'h0, exp}, rd);
			check("status resp", {30'h0, `RESP_OKAY}, {30'h0, rs});
			axi_read(addr(`IDX_BATT), rd, rs);
			check("battery", {20'h0, m_res[6]}, rd);
			axi_read(addr(`IDX_TEMP), rd, rs);
			check("temperature", {20'h0, m_res[7]}, rd);
			axi_read(addr(`IDX_CFG2), rd, rs);
			check("config two", {16'h0, m_cfg[1]}, rd);
			axi_read(addr(`IDX_ENA), rd, rs);
			check("enables rb", {28'h0, m_ena}, rd);
		end
		// state-machine reset drops enables and source fields only
		axi_write(addr(`IDX_ENA), 32'hf, `RESP_OKAY);
		sm_reset_i <= 1'b1;
		@(posedge core_clk_i);
		sm_reset_i <= 1'b0;
		axi_read(addr(`IDX_ENA), rd, rs);
		check("enables", 32'h0, rd);
		axi_read(addr(`IDX_CFG1), rd, rs);
		check("config one", {16'h0, m_cfg[0] & 16'h1fff}, rd);
		// a low-byte-only write must leave the upper config byte alone
		s_axi_wstrb <= 4'h1;
		axi_write(addr(`IDX_CFG2), 32'h0000_ffff, `RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		axi_read(addr(`IDX_CFG2), rd, rs);
		check("config two strobe", {16'h0, (m_cfg[1] & 16'h1f00) | 16'h00ff}, rd);
		report_and_stop();
	end

	// a hang ends the run as a failure
	always @(posedge core_clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end
endmodule
